// File: src/duop_pkg.sv
package duop_pkg;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned PINS_W   = 8;
  localparam int unsigned SYNC_W   = 1 + 1 + 1 + ADDR_W + DATA_W;
  localparam int unsigned COND_W   = 8;

  // Host-visible register addresses
  localparam logic [3:0] ADDR_OUT_PORT = 4'h0;
  localparam logic [3:0] ADDR_FUNC_SEL = 4'h1;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;
  localparam logic [3:0] ADDR_IRQ_COND = 4'h3;

  // Reset values
  localparam logic [7:0] OUT_PORT_RST = 8'hFF;
  localparam logic [7:0] FUNC_SEL_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] PINS_RST     = 8'hFF;
  localparam logic [7:0] DATA_RST     = 8'h00;

  // Function select field positions
  localparam int unsigned FS_RTS_B    = 1;
  localparam int unsigned FS_PIN3_LSB = 2;
  localparam int unsigned FS_FULL_B   = 4;
  localparam int unsigned FS_RXIND_B  = 5;
  localparam int unsigned FS_TX_READY_CHAN_A_N  = 6;
  localparam int unsigned FS_TX_READY_CHAN_B_N  = 7;

  // Pin three function codes
  localparam logic [1:0] PIN3_GENERAL = 2'h0;
  localparam logic [1:0] PIN3_TX_CLK  = 2'h1;
  localparam logic [1:0] PIN3_RX_CLK  = 2'h2;
  localparam logic [1:0] PIN3_CT_RDY  = 2'h3;

  // Pin indices
  localparam int unsigned PIN_GENERAL_OUTPUT_ONE   = 1;
  localparam int unsigned PIN_GENERAL_OUTPUT_THREE = 3;
  localparam int unsigned PIN_GENERAL_OUTPUT_FIVE  = 5;
  localparam int unsigned PIN_GENERAL_OUTPUT_SIX   = 6;
  localparam int unsigned PIN_GENERAL_OUTPUT_SEVEN = 7;
endpackage : duop_pkg

// File: src/duop_host_if.sv
`timescale 1ns/10ps
interface duop_host_if;
  import duop_pkg::*;
  logic              cs_n;
  logic              rd_n;
  logic              wr_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  modport src (output cs_n, output rd_n, output wr_n, output addr, output wdata);
  modport dst (input cs_n, input rd_n, input wr_n, input addr, input wdata);
endinterface : duop_host_if

// File: src/duop_pin_sync.sv
`timescale 1ns/10ps
module duop_pin_sync (
  input  wire logic                      clk_in,
  input  wire logic                      rst_b_in,
  input  wire logic                      chip_select_n_in,
  input  wire logic                      read_strobe_n_in,
  input  wire logic                      write_strobe_n_in,
  input  wire logic [duop_pkg::ADDR_W-1:0] address_in,
  input  wire logic [duop_pkg::DATA_W-1:0] host_data_bus_in,
  duop_host_if.src                       host
);
  import duop_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] filt;
  } duop_sync_s;

  duop_sync_s st_reg;
  duop_sync_s st_next;
  logic [SYNC_W-1:0] raw;

  assign raw = {chip_select_n_in, read_strobe_n_in, write_strobe_n_in, address_in,
                host_data_bus_in};

  // A bit only moves once stages two and three agree, which rejects one-cycle glitches
  always_comb begin
    st_next      = st_reg;
    st_next.s1   = raw;
    st_next.s2   = st_reg.s1;
    st_next.s3   = st_reg.s2;
    st_next.filt = (st_reg.s2 & st_reg.s3) | (st_reg.filt & (st_reg.s2 | st_reg.s3));
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_reg <= {4{{3{1'b1}}, {(ADDR_W + DATA_W){1'b0}}}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign host.cs_n  = st_reg.filt[SYNC_W-1];
  assign host.rd_n  = st_reg.filt[SYNC_W-2];
  assign host.wr_n  = st_reg.filt[SYNC_W-3];
  assign host.addr  = st_reg.filt[DATA_W +: ADDR_W];
  assign host.wdata = st_reg.filt[DATA_W-1:0];

  AST_FILT_STABLE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (st_reg.s2 == st_reg.s3) |=> (st_reg.filt == $past(st_reg.s3)))
    else $error("Filtered pin value did not follow agreeing stages");
endmodule : duop_pin_sync

// File: src/duop_port.sv
// Function
// - Pin one: general output or channel B RTS
// - Pin three: tx clock, rx clock, timer ready
// - Pin five: open-drain rx ready or full
// - Pin seven: open-drain channel B tx ready
// - Pin six: open-drain channel A tx ready
// - Eight-bit host data bus, bit seven MSB
// - Bus floats when deselected, except Z-mode acknowledge
// - Interrupt pulls low on any unmasked condition
// - Interrupt held until all causes removed
// - Write captured on write strobe rising edge
// - Read drives addressed register while selected
// - Reset: pins high, timer stopped, outputs marking
`timescale 1ns/10ps
module duop_port (
  input  wire logic                        clk_in,
  input  wire logic                        rst_b_in,
  input  wire logic                        chip_select_n_in,
  input  wire logic                        read_strobe_n_in,
  input  wire logic                        write_strobe_n_in,
  input  wire logic [duop_pkg::ADDR_W-1:0] address_in,
  input  wire logic [duop_pkg::DATA_W-1:0] host_data_bus_in,
  output logic      [duop_pkg::DATA_W-1:0] host_data_bus_out,
  output logic                             host_data_bus_oe_out,
  input  wire logic                        interrupt_acknowledge_cycle_in,
  input  wire logic                        z_mode_in,
  input  wire logic [duop_pkg::DATA_W-1:0] interrupt_vector_in,
  input  wire logic                        request_to_send_chan_b_n_in,
  input  wire logic                        tx_clock_chan_b_single_rate_in,
  input  wire logic                        rx_clock_chan_b_single_rate_in,
  input  wire logic                        timer_ready_in,
  input  wire logic                        rx_ready_chan_b_in,
  input  wire logic                        rx_fifo_full_chan_b_in,
  input  wire logic                        tx_ready_chan_a_in,
  input  wire logic                        tx_ready_chan_b_in,
  input  wire logic [duop_pkg::COND_W-1:0] irq_conditions_in,
  input  wire logic                        serial_chan_a_in,
  input  wire logic                        serial_chan_b_in,
  output logic      [duop_pkg::PINS_W-1:0] output_port_pins_out,
  output logic      [duop_pkg::PINS_W-1:0] output_port_pins_oe_out,
  output logic                             interrupt_request_n_out,
  output logic                             interrupt_request_n_oe_out,
  output logic                             serial_out_chan_a_out,
  output logic                             serial_out_chan_b_out,
  output logic                             timer_run_out
);
  import duop_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] out_port;
    logic [DATA_W-1:0] func_sel;
    logic [DATA_W-1:0] irq_mask;
    logic              wr_armed;
    logic [PINS_W-1:0] pins;
    logic [PINS_W-1:0] pins_oe;
    logic [DATA_W-1:0] dout;
    logic              dout_oe;
    logic              irq_oe;
    logic              ser_a;
    logic              ser_b;
    logic              timer_run;
  } duop_port_s;

  duop_port_s  st_reg;
  duop_port_s  st_next;
  duop_host_if host ();

  logic        wr_commit;
  logic        rd_active;
  logic        interrupt_acknowledge_cycle_drive;
  logic [1:0]  pin3_mode;
  logic [DATA_W-1:0] rd_data;

  duop_pin_sync u_sync (
    .clk_in            (clk_in),
    .rst_b_in          (rst_b_in),
    .chip_select_n_in  (chip_select_n_in),
    .read_strobe_n_in  (read_strobe_n_in),
    .write_strobe_n_in (write_strobe_n_in),
    .address_in        (address_in),
    .host_data_bus_in  (host_data_bus_in),
    .host              (host.src)
  );

  assign pin3_mode  = st_reg.func_sel[FS_PIN3_LSB +: 2];
  assign wr_commit  = st_reg.wr_armed && host.wr_n;
  assign rd_active  = !host.cs_n && !host.rd_n;
  assign interrupt_acknowledge_cycle_drive = z_mode_in && interrupt_acknowledge_cycle_in;

  always_comb begin
    case (host.addr)
      ADDR_OUT_PORT: rd_data = st_reg.out_port;
      ADDR_FUNC_SEL: rd_data = st_reg.func_sel;
      ADDR_IRQ_MASK: rd_data = st_reg.irq_mask;
      ADDR_IRQ_COND: rd_data = irq_conditions_in;
      default:       rd_data = 8'h00;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    // Write is armed while strobe and select are low and lands on the strobe's rise
    st_next.wr_armed = !host.cs_n && !host.wr_n;
    if (wr_commit) begin
      case (host.addr)
        ADDR_OUT_PORT: st_next.out_port = host.wdata;
        ADDR_FUNC_SEL: st_next.func_sel = host.wdata;
        ADDR_IRQ_MASK: st_next.irq_mask = host.wdata;
        default:       st_next.out_port = st_reg.out_port;
      endcase
    end

    // Push-pull general outputs by default
    st_next.pins    = st_reg.out_port;
    st_next.pins_oe = 8'hFF;
    if (st_reg.func_sel[FS_RTS_B]) begin
      st_next.pins[PIN_GENERAL_OUTPUT_ONE] = request_to_send_chan_b_n_in;
    end
    case (pin3_mode)
      PIN3_TX_CLK: st_next.pins[PIN_GENERAL_OUTPUT_THREE] = tx_clock_chan_b_single_rate_in;
      PIN3_RX_CLK: st_next.pins[PIN_GENERAL_OUTPUT_THREE] = rx_clock_chan_b_single_rate_in;
      PIN3_CT_RDY: begin
        st_next.pins[PIN_GENERAL_OUTPUT_THREE]    = 1'b0;
        st_next.pins_oe[PIN_GENERAL_OUTPUT_THREE] = timer_ready_in;
      end
      default: st_next.pins[PIN_GENERAL_OUTPUT_THREE] = st_reg.out_port[PIN_GENERAL_OUTPUT_THREE];
    endcase
    if (st_reg.func_sel[FS_RXIND_B]) begin
      st_next.pins[PIN_GENERAL_OUTPUT_FIVE]    = 1'b0;
      st_next.pins_oe[PIN_GENERAL_OUTPUT_FIVE] = st_reg.func_sel[FS_FULL_B] ?
        rx_fifo_full_chan_b_in : rx_ready_chan_b_in;
    end
    if (st_reg.func_sel[FS_TX_READY_CHAN_A_N]) begin
      st_next.pins[PIN_GENERAL_OUTPUT_SIX]    = 1'b0;
      st_next.pins_oe[PIN_GENERAL_OUTPUT_SIX] = tx_ready_chan_a_in;
    end
    if (st_reg.func_sel[FS_TX_READY_CHAN_B_N]) begin
      st_next.pins[PIN_GENERAL_OUTPUT_SEVEN]    = 1'b0;
      st_next.pins_oe[PIN_GENERAL_OUTPUT_SEVEN] = tx_ready_chan_b_in;
    end

    // Acknowledge vector takes priority, it is the only drive allowed while deselected
    if (interrupt_acknowledge_cycle_drive) begin
      st_next.dout    = interrupt_vector_in;
      st_next.dout_oe = 1'b1;
    end else if (rd_active) begin
      st_next.dout    = rd_data;
      st_next.dout_oe = 1'b1;
    end else begin
      st_next.dout    = DATA_RST;
      st_next.dout_oe = 1'b0;
    end

    // Pure level: no latching, so release follows removal of the last cause
    st_next.irq_oe    = |(irq_conditions_in & st_reg.irq_mask);
    st_next.ser_a     = serial_chan_a_in;
    st_next.ser_b     = serial_chan_b_in;
    st_next.timer_run = 1'b1;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_reg.out_port  <= OUT_PORT_RST;
      st_reg.func_sel  <= FUNC_SEL_RST;
      st_reg.irq_mask  <= IRQ_MASK_RST;
      st_reg.wr_armed  <= 1'b0;
      st_reg.pins      <= PINS_RST;
      st_reg.pins_oe   <= 8'hFF;
      st_reg.dout      <= DATA_RST;
      st_reg.dout_oe   <= 1'b0;
      st_reg.irq_oe    <= 1'b0;
      st_reg.ser_a     <= 1'b1;
      st_reg.ser_b     <= 1'b1;
      st_reg.timer_run <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign host_data_bus_out          = st_reg.dout;
  assign host_data_bus_oe_out       = st_reg.dout_oe;
  assign output_port_pins_out       = st_reg.pins;
  assign output_port_pins_oe_out    = st_reg.pins_oe;
  assign interrupt_request_n_out    = 1'b0;
  assign interrupt_request_n_oe_out = st_reg.irq_oe;
  assign serial_out_chan_a_out      = st_reg.ser_a;
  assign serial_out_chan_b_out      = st_reg.ser_b;
  assign timer_run_out              = st_reg.timer_run;

  sequence s_write_done;
    (!host.cs_n && !host.wr_n) ##1 (host.wr_n && host.addr == ADDR_OUT_PORT);
  endsequence

  sequence s_read_open;
    !host.cs_n && !host.rd_n && !interrupt_acknowledge_cycle_drive;
  endsequence

  AST_RTS_B: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    st_reg.func_sel[FS_RTS_B] |=>
      output_port_pins_out[PIN_GENERAL_OUTPUT_ONE] == $past(request_to_send_chan_b_n_in))
    else $error("Pin one does not follow channel B RTS");
  AST_PIN3_CT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (pin3_mode == PIN3_CT_RDY) |=> !output_port_pins_out[PIN_GENERAL_OUTPUT_THREE] &&
      output_port_pins_oe_out[PIN_GENERAL_OUTPUT_THREE] == $past(timer_ready_in))
    else $error("Pin three timer ready wrong");
  AST_PIN5_RX: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (st_reg.func_sel[FS_RXIND_B] && !st_reg.func_sel[FS_FULL_B]) |=>
      output_port_pins_oe_out[PIN_GENERAL_OUTPUT_FIVE] == $past(rx_ready_chan_b_in))
    else $error("Pin five receive ready wrong");
  AST_PIN7_TX: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    st_reg.func_sel[FS_TX_READY_CHAN_B_N] |=>
      output_port_pins_oe_out[PIN_GENERAL_OUTPUT_SEVEN] == $past(tx_ready_chan_b_in))
    else $error("Pin seven transmit ready wrong");
  AST_PIN6_TX: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    st_reg.func_sel[FS_TX_READY_CHAN_A_N] |=>
      output_port_pins_oe_out[PIN_GENERAL_OUTPUT_SIX] == $past(tx_ready_chan_a_in))
    else $error("Pin six transmit ready wrong");
  AST_BUS_FLOAT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (host.cs_n && !interrupt_acknowledge_cycle_drive) |=> !host_data_bus_oe_out)
    else $error("Data bus driven while deselected");
  AST_WRITE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_write_done |=> ##1 output_port_pins_out[0] == $past(host.wdata[0], 2))
    else $error("Write not captured on strobe rise");
  AST_READ: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_read_open |=> host_data_bus_oe_out && host_data_bus_out == $past(rd_data))
    else $error("Read data not driven");
  AST_IRQ_SET: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (|(irq_conditions_in & st_reg.irq_mask)) |=> interrupt_request_n_oe_out)
    else $error("Interrupt not asserted for unmasked condition");
  AST_IRQ_HOLD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !(|(irq_conditions_in & st_reg.irq_mask)) |=> !interrupt_request_n_oe_out)
    else $error("Interrupt held without a cause");
  AST_RESET: assert property (@(posedge clk_in)
    !rst_b_in |=> output_port_pins_out == PINS_RST && serial_out_chan_a_out &&
      serial_out_chan_b_out && !timer_run_out)
    else $error("Reset state wrong");
endmodule : duop_port

// File: verification/duop_host_model.sv
`timescale 1ns/10ps
module duop_host_model (
  input  wire logic                        clk_in,
  input  wire logic [duop_pkg::DATA_W-1:0] bus_in,
  output logic                             cs_n_out,
  output logic                             rd_n_out,
  output logic                             wr_n_out,
  output logic      [duop_pkg::ADDR_W-1:0] addr_out,
  output logic      [duop_pkg::DATA_W-1:0] data_out,
  output logic                             drive_out
);
  import duop_pkg::*;
  initial begin
    {cs_n_out, rd_n_out, wr_n_out} = 3'h7;
    addr_out  = 4'h0;
    data_out  = 8'h00;
    drive_out = 1'b0;
  end
  // Eight clocks each side of a strobe edge covers the four-flop pin filter
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk_in);
    addr_out  = a;
    data_out  = d;
    drive_out = 1'b1;
    cs_n_out  = 1'b0;
    wr_n_out  = 1'b0;
    repeat (8) @(negedge clk_in);
    wr_n_out  = 1'b1;
    repeat (8) @(negedge clk_in);
    cs_n_out  = 1'b1;
    drive_out = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask : write_reg
  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(negedge clk_in);
    addr_out = a;
    cs_n_out = 1'b0;
    rd_n_out = 1'b0;
    repeat (8) @(negedge clk_in);
    d        = bus_in;
    rd_n_out = 1'b1;
    cs_n_out = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask : read_reg
endmodule : duop_host_model

// File: verification/duop_port_tb_top.sv
`timescale 1ns/10ps
module duop_port_tb_top;
  import duop_pkg::*;
  logic       clk_in = 1'b0;
  logic       rst_b_in, cs_n, rd_n, wr_n, hdrv, oe, irq_n, irq_oe, so_a, so_b, trun;
  logic       interrupt_acknowledge_cycle, zm, sa, sb;
  logic [3:0] addr;
  logic [7:0] bus, dout, hdata, vec, ind, cond, pins, pins_oe, fs, port, mask, rd;
  logic [7:0] last_bus = 8'h00;
  int         seed = 49;
  int         failures = 0;
  int         checks = 0;
  always #5 clk_in = ~clk_in;
  // A released bus shows the inverse of its last level, never a held value
  assign bus = oe ? dout : (hdrv ? hdata : ~last_bus);
  always @(posedge clk_in) last_bus <= bus;
  duop_host_model duop_host_model_i (.clk_in(clk_in), .bus_in(bus), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .addr_out(addr), .data_out(hdata), .drive_out(hdrv));
  duop_port duop_port_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .chip_select_n_in(cs_n),
    .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n), .address_in(addr),
    .host_data_bus_in(bus), .host_data_bus_out(dout), .host_data_bus_oe_out(oe),
    .interrupt_acknowledge_cycle_in(interrupt_acknowledge_cycle), .z_mode_in(zm), .interrupt_vector_in(vec),
    .request_to_send_chan_b_n_in(ind[0]), .tx_clock_chan_b_single_rate_in(ind[1]),
    .rx_clock_chan_b_single_rate_in(ind[2]), .timer_ready_in(ind[3]),
    .rx_ready_chan_b_in(ind[4]), .rx_fifo_full_chan_b_in(ind[5]),
    .tx_ready_chan_a_in(ind[6]), .tx_ready_chan_b_in(ind[7]), .irq_conditions_in(cond),
    .serial_chan_a_in(sa), .serial_chan_b_in(sb), .output_port_pins_out(pins),
    .output_port_pins_oe_out(pins_oe), .interrupt_request_n_out(irq_n),
    .interrupt_request_n_oe_out(irq_oe), .serial_out_chan_a_out(so_a),
    .serial_out_chan_b_out(so_b), .timer_run_out(trun));
  // Returns care mask, enable and level; open-drain pins carry no level when idle
  function automatic logic [23:0] exp_pins(input logic [7:0] f, p, s);
    logic [7:0] o, odm, act;
    o   = p;
    odm = 8'h00;
    act = 8'h00;
    if (f[FS_RTS_B]) o[1] = s[0];
    if (f[3:2] == PIN3_TX_CLK) o[3] = s[1];
    if (f[3:2] == PIN3_RX_CLK) o[3] = s[2];
    odm[3] = (f[3:2] == PIN3_CT_RDY);
    act[3] = s[3];
    odm[5] = f[FS_RXIND_B];
    act[5] = f[FS_FULL_B] ? s[5] : s[4];
    odm[6] = f[FS_TX_READY_CHAN_A_N];
    act[6] = s[6];
    odm[7] = f[FS_TX_READY_CHAN_B_N];
    act[7] = s[7];
    return {~odm | act, ~odm | act, o & ~odm};
  endfunction : exp_pins
  task automatic check(input logic [7:0] seen, exp, input string msg);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check
  task automatic close_out();
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic step();
    logic [23:0] x;
    logic [31:0] r;
    @(negedge clk_in);
    // Upper bits feed acknowledge, mode and serial so every input sees random values
    r = $random(seed);
    {ind, cond, vec} = r[23:0];
    {interrupt_acknowledge_cycle, zm, sa, sb} = r[27:24];
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    x = exp_pins(fs, port, ind);
    check(pins & x[23:16], x[7:0], "pin level");
    check(pins_oe, x[15:8], "pin enable");
    check({6'h0, irq_oe, irq_n}, {6'h0, |(cond & mask), 1'b0}, "irq");
    check({7'h0, oe}, {7'h0, zm & interrupt_acknowledge_cycle}, "bus float");
    if (zm & interrupt_acknowledge_cycle) check(dout, vec, "vector");
    check({5'h0, so_a, so_b, trun}, {5'h0, sa, sb, 1'b1}, "serial");
    {interrupt_acknowledge_cycle, zm} = 2'h0;
  endtask : step
  initial begin
    logic [7:0] fs_tab [4];
    fs_tab = '{8'hF2, 8'hC4, 8'hF8, 8'hEC};
    {rst_b_in, interrupt_acknowledge_cycle, zm, sa, sb, vec, ind, cond} = {1'b0, 4'h3, 8'h00, 8'h00, 8'hFF};
    {fs, port, mask} = {FUNC_SEL_RST, OUT_PORT_RST, IRQ_MASK_RST};
    repeat (6) @(negedge clk_in);
    check(pins, PINS_RST, "reset pins");
    check(pins_oe, 8'hFF, "reset enables");
    check({4'h0, oe, irq_oe, so_a & so_b, trun}, 8'h02, "reset outputs");
    {interrupt_acknowledge_cycle, zm} = 2'h0;
    rst_b_in = 1'b1;
    repeat (4) @(negedge clk_in);
    for (int i = 0; i < 10; i++) begin
      fs   = (i < 4) ? fs_tab[i] : 8'($random(seed));
      port = (i == 0) ? 8'h00 : 8'($random(seed));
      mask = (i == 1) ? 8'hFF : 8'($random(seed));
      duop_host_model_i.write_reg(ADDR_FUNC_SEL, fs);
      duop_host_model_i.write_reg(ADDR_OUT_PORT, port);
      duop_host_model_i.write_reg(ADDR_IRQ_MASK, mask);
      duop_host_model_i.write_reg(ADDR_IRQ_COND, ~mask);
      duop_host_model_i.read_reg(ADDR_FUNC_SEL, rd);
      check(rd, fs, "read func");
      duop_host_model_i.read_reg(ADDR_OUT_PORT, rd);
      check(rd, port, "read port");
      duop_host_model_i.read_reg(ADDR_IRQ_MASK, rd);
      check(rd, mask, "read mask");
      duop_host_model_i.read_reg(ADDR_IRQ_COND, rd);
      check(rd, cond, "read causes");
      duop_host_model_i.read_reg(4'h4 + i[3:0] % 4'hC, rd);
      check(rd, 8'h00, "unmapped read");
      repeat (6) step();
    end
    rst_b_in = 1'b0;
    repeat (2) @(negedge clk_in);
    check(pins, PINS_RST, "second reset");
    rst_b_in = 1'b1;
    {fs, port, mask} = {FUNC_SEL_RST, OUT_PORT_RST, IRQ_MASK_RST};
    repeat (4) @(negedge clk_in);
    duop_host_model_i.read_reg(ADDR_FUNC_SEL, rd);
    check(rd, FUNC_SEL_RST, "func after reset");
    step();
    close_out();
  end
  initial begin
    #200000;
    failures++;
    close_out();
  end
endmodule : duop_port_tb_top
